// [hw/dspi2c_device.sv]
// display-side two-wire register slave
//
// Overview of operation
// - write: address, register index, data byte
// - read: address, index, repeated address, data
// - slave only; never drives the clock
// - address 011101 plus select pin bit
// - host writes use 74h or 76h
// - host reads use 75h or 77h
// - sequential bytes go to next register
// - host holds STOP until bytes done
// - host clock at most 400 kHz
// - decoded index selects written register
// - registers read back stored values
// - write protect bit locks other registers
// - writes refused while reset pin low
`timescale 1ns/10ps
module dspi2c_device (
	// system
	input  wire logic SYS_CLK,
	input  wire logic ARST_N,
	// bus
	dspi2c_if.device  BUS,
	// pins
	input  wire logic ADDRESS_SELECT_PIN,
	input  wire logic EXTERNAL_RESET_PIN,
	// status
	output logic      BUSY,
	output logic [7:0] MODE_REG
);
	// ---------------------------------------------------------------
	// synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [1:0] scl_s, sda_s, sel_s, rst_s;
	logic       scl_q, sda_q;
	logic [1:0] next_scl_s, next_sda_s, next_sel_s, next_rst_s;
	always_comb begin
		next_scl_s = {scl_s[0], BUS.scl};
		next_sda_s = {sda_s[0], BUS.sda};
		next_sel_s = {sel_s[0], ADDRESS_SELECT_PIN};
		next_rst_s = {rst_s[0], EXTERNAL_RESET_PIN};
	end
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			sel_s <= 2'h0;
			rst_s <= 2'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= next_scl_s;
			sda_s <= next_sda_s;
			sel_s <= next_sel_s;
			rst_s <= next_rst_s;
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end
	logic scl_rise, scl_fall, start_c, stop_c;
	assign scl_rise = scl_s[1] && !scl_q;
	assign scl_fall = !scl_s[1] && scl_q;
	assign start_c  = scl_s[1] && scl_q && sda_q && !sda_s[1];
	assign stop_c   = scl_s[1] && scl_q && !sda_q && sda_s[1];

	// ---------------------------------------------------------------
	// protocol engine
	// ---------------------------------------------------------------
	logic [7:0] regs [dspi2c_pkg::REG_COUNT];
	dspi2c_pkg::dspi2c_dstate_t state, next_state;
	logic [7:0] shreg, next_shreg, index, next_index, txb, next_txb;
	logic [2:0] bitc, next_bitc;
	logic       first, next_first, sda_oe, next_sda_oe, nack, next_nack;
	logic       full, next_full;
	logic       we;

	function automatic logic [7:0] rd_reg(input logic [7:0] idx, input logic [7:0] r [dspi2c_pkg::REG_COUNT]);
		if (idx == 8'h00)
			rd_reg = dspi2c_pkg::REG_ID_VALUE;
		else if (idx < 8'(dspi2c_pkg::REG_COUNT))
			rd_reg = r[idx[4:0]];
		else
			rd_reg = 8'h00;
	endfunction

	// next-state logic; sda sampled on scl rise, driven after scl fall
	always_comb begin
		next_state  = state;
		next_shreg  = shreg;
		next_index  = index;
		next_txb    = txb;
		next_bitc   = bitc;
		next_first  = first;
		next_sda_oe = sda_oe;
		next_nack   = nack;
		next_full   = full;
		we          = 1'b0;
		if (start_c) begin
			next_state  = dspi2c_pkg::DS_ADDR;
			next_bitc   = 3'h0;
			next_full   = 1'b0;
			next_sda_oe = 1'b0;
		end else if (stop_c) begin
			next_state  = dspi2c_pkg::DS_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				dspi2c_pkg::DS_ADDR, dspi2c_pkg::DS_RADDR, dspi2c_pkg::DS_WDATA: begin
					if (scl_rise) begin
						next_shreg = {shreg[6:0], sda_s[1]};
						next_bitc  = bitc + 3'h1;
						next_full  = (bitc == 3'h7);
					end
					// full guards the first fall after start, where bitc is also zero
					if (scl_fall && full && state != dspi2c_pkg::DS_ADDR) begin
						// fall after eighth bit: acknowledge
						next_full   = 1'b0;
						next_sda_oe = 1'b1;
						next_state  = dspi2c_pkg::DS_WACK;
						if (state == dspi2c_pkg::DS_RADDR)
							next_index = shreg;
						else if (rst_s[1] && (index == dspi2c_pkg::REG_MODE ||
							!MODE_REG[dspi2c_pkg::WPROT_BIT])) begin
							we = (index != 8'h00) && (index < 8'(dspi2c_pkg::REG_COUNT));
						end
						if (state == dspi2c_pkg::DS_WDATA)
							next_index = index + 8'h01;
					end else if (scl_fall && full && state == dspi2c_pkg::DS_ADDR) begin
						next_full = 1'b0;
						if (shreg[7:1] == {dspi2c_pkg::ADDR_UPPER, sel_s[1]}) begin
							next_sda_oe = 1'b1;
							next_first  = !shreg[0];
							next_state  = dspi2c_pkg::DS_AACK;
						end else begin
							next_state  = dspi2c_pkg::DS_IDLE;
						end
					end
				end
				dspi2c_pkg::DS_AACK: begin
					if (scl_fall) begin
						next_bitc = 3'h0;
						if (first) begin
							next_sda_oe = 1'b0;
							next_state  = dspi2c_pkg::DS_RADDR;
						end else begin
							next_txb    = rd_reg(index, regs);
							next_sda_oe = !next_txb[7];
							next_state  = dspi2c_pkg::DS_RDATA;
						end
					end
				end
				dspi2c_pkg::DS_WACK: begin
					if (scl_fall) begin
						next_sda_oe = 1'b0;
						next_bitc   = 3'h0;
						next_state  = dspi2c_pkg::DS_WDATA;
					end
				end
				dspi2c_pkg::DS_RDATA: begin
					if (scl_fall) begin
						next_bitc = bitc + 3'h1;
						if (bitc == 3'h7) begin
							next_sda_oe = 1'b0;                     // release for host ack
							next_state  = dspi2c_pkg::DS_RACK;
						end else begin
							next_txb    = {txb[6:0], 1'b0};
							next_sda_oe = !txb[6];
						end
					end
				end
				dspi2c_pkg::DS_RACK: begin
					if (scl_rise)
						next_nack = sda_s[1];
					if (scl_fall) begin
						if (nack) begin
							next_state = dspi2c_pkg::DS_IDLE;
						end else begin
							next_index  = index + 8'h01;
							next_txb    = rd_reg(index + 8'h01, regs);
							next_sda_oe = !next_txb[7];
							next_bitc   = 3'h0;
							next_state  = dspi2c_pkg::DS_RDATA;
						end
					end
				end
				default: next_state = dspi2c_pkg::DS_IDLE;
			endcase
		end
	end

	// register the engine; data never drives scl
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state  <= dspi2c_pkg::DS_IDLE;
			shreg  <= 8'h00;
			index  <= 8'h00;
			txb    <= 8'h00;
			bitc   <= 3'h0;
			first  <= 1'b0;
			sda_oe <= 1'b0;
			nack   <= 1'b0;
			full   <= 1'b0;
			BUSY   <= 1'b0;
			MODE_REG <= dspi2c_pkg::REG_RESET;
			for (int i = 0; i < dspi2c_pkg::REG_COUNT; i++)
				regs[i] <= dspi2c_pkg::REG_RESET;
		end else begin
			state  <= next_state;
			shreg  <= next_shreg;
			index  <= next_index;
			txb    <= next_txb;
			bitc   <= next_bitc;
			first  <= next_first;
			sda_oe <= next_sda_oe;
			nack   <= next_nack;
			full   <= next_full;
			BUSY   <= (next_state != dspi2c_pkg::DS_IDLE);
			if (we) begin
				regs[index[4:0]] <= shreg;
				if (index == dspi2c_pkg::REG_MODE)
					MODE_REG <= shreg;
			end
		end
	end
	assign BUS.sda_d_o  = 1'b0;
	assign BUS.sda_d_oe = sda_oe;
endmodule

// [hw/dspi2c_host.sv]
// host-side two-wire master for register access
`timescale 1ns/10ps
module dspi2c_host (
	// system
	input  wire logic       SYS_CLK,
	input  wire logic       ARST_N,
	// bus
	dspi2c_if.host          BUS,
	// command
	input  wire logic       REQ,
	input  wire logic       RD,
	input  wire logic       SEL,
	input  wire logic [7:0] INDEX,
	input  wire logic [7:0] WDATA,
	// answer
	output logic            DONE,
	output logic            ERR,
	output logic [7:0]      RDATA
);
	// ---------------------------------------------------------------
	// bit engine: one byte list per transfer, clock derived by divider
	// ---------------------------------------------------------------
	dspi2c_pkg::dspi2c_hstate_t state, next_state;
	logic [7:0] cnt, next_cnt, sh, next_sh, rx, next_rx;
	logic [2:0] bitc, next_bitc;
	logic [1:0] byten, next_byten;
	logic       ph, next_ph, scl, next_scl, sda, next_sda, rd, next_rd;
	logic       rep, next_rep, err, next_err;
	logic [7:0] idx, next_idx, wd, next_wd;
	logic       sel, next_sel;
	logic [1:0] sda_s;

	// address bytes: 74h/76h write, 75h/77h read
	function automatic logic [7:0] addr_byte(input logic s, input logic r);
		addr_byte = {dspi2c_pkg::ADDR_UPPER, s, r};
	endfunction

	always_comb begin
		next_state = state; next_cnt = cnt; next_sh = sh; next_rx = rx;
		next_bitc = bitc; next_byten = byten; next_ph = ph; next_scl = scl;
		next_sda = sda; next_rd = rd; next_rep = rep; next_err = err;
		next_idx = idx; next_wd = wd; next_sel = sel;
		if (state != dspi2c_pkg::HS_IDLE)
			next_cnt = (cnt == dspi2c_pkg::HALF_COUNT - 8'h01) ? 8'h00 : cnt + 8'h01;
		case (state)
			dspi2c_pkg::HS_IDLE: begin
				if (REQ) begin
					next_idx = INDEX; next_wd = WDATA; next_sel = SEL; next_rd = RD;
					next_rep = 1'b0; next_err = 1'b0; next_cnt = 8'h00; next_ph = 1'b0;
					next_state = dspi2c_pkg::HS_START;
				end
			end
			// clock raised first so a repeated start sees data fall while it is high
			dspi2c_pkg::HS_START: begin
				if (cnt == dspi2c_pkg::QTR_COUNT && ph) begin
					next_sda = 1'b0;
					next_sh = addr_byte(sel, rep);
					next_byten = 2'h0; next_bitc = 3'h0;
				end
				if (cnt == dspi2c_pkg::HALF_COUNT - 8'h01) begin
					next_ph = !ph;
					next_scl = !ph;
					if (ph) next_state = dspi2c_pkg::HS_BIT;
				end
			end
			dspi2c_pkg::HS_BIT, dspi2c_pkg::HS_ACK: begin
				if (cnt == dspi2c_pkg::QTR_COUNT && !ph)
					next_sda = (state == dspi2c_pkg::HS_ACK) ? 1'b1 :
						((rep && byten == 2'h1) ? 1'b1 : sh[7]);
				if (cnt == dspi2c_pkg::HALF_COUNT - 8'h01) begin
					next_ph = !ph;
					next_scl = !ph;
					if (!ph && state == dspi2c_pkg::HS_BIT)
						next_rx = {rx[6:0], sda_s[1]};
					if (!ph && state == dspi2c_pkg::HS_ACK && !(rep && byten == 2'h1))
						next_err = sda_s[1];                        // device nack
					if (ph && state == dspi2c_pkg::HS_BIT) begin
						next_sh = {sh[6:0], 1'b0};
						next_bitc = bitc + 3'h1;
						if (bitc == 3'h7) next_state = dspi2c_pkg::HS_ACK;
					end else if (ph) begin
						next_byten = byten + 2'h1;
						next_state = dspi2c_pkg::HS_BIT;
						if (err || (rep && byten == 2'h1) || (!rd && byten == 2'h2)) begin
							next_state = dspi2c_pkg::HS_STOP;
						end else if (rd && byten == 2'h1) begin
							next_rep = 1'b1;                        // repeated start
							next_sda = 1'b1;
							next_state = dspi2c_pkg::HS_START;
						end else begin
							next_sh = (byten == 2'h0) ? idx : wd;
						end
					end
				end
			end
			dspi2c_pkg::HS_STOP: begin
				if (cnt == dspi2c_pkg::QTR_COUNT) next_sda = 1'b0;
				if (cnt == dspi2c_pkg::HALF_COUNT - 8'h01) begin
					next_ph = !ph;
					if (!ph) next_scl = 1'b1;
					else begin
						next_sda = 1'b1;
						next_state = dspi2c_pkg::HS_DONE;
					end
				end
			end
			default: next_state = dspi2c_pkg::HS_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= dspi2c_pkg::HS_IDLE; cnt <= 8'h00; sh <= 8'h00; rx <= 8'h00;
			bitc <= 3'h0; byten <= 2'h0; ph <= 1'b0; scl <= 1'b1; sda <= 1'b1;
			rd <= 1'b0; rep <= 1'b0; err <= 1'b0; idx <= 8'h00; wd <= 8'h00; sel <= 1'b0;
			sda_s <= 2'h3; DONE <= 1'b0; ERR <= 1'b0; RDATA <= 8'h00;
		end else begin
			state <= (state == dspi2c_pkg::HS_DONE) ? dspi2c_pkg::HS_IDLE : next_state;
			cnt <= next_cnt; sh <= next_sh; rx <= next_rx; bitc <= next_bitc;
			byten <= next_byten; ph <= next_ph; scl <= next_scl; sda <= next_sda;
			rd <= next_rd; rep <= next_rep; err <= next_err; idx <= next_idx;
			wd <= next_wd; sel <= next_sel;
			sda_s <= {sda_s[0], BUS.sda};
			DONE <= (state == dspi2c_pkg::HS_DONE);
			if (state == dspi2c_pkg::HS_DONE) begin
				ERR <= err;
				RDATA <= rx;
			end
		end
	end
	assign BUS.scl_o    = 1'b0;
	assign BUS.scl_oe   = !scl;
	assign BUS.sda_h_o  = 1'b0;
	assign BUS.sda_h_oe = !sda;
endmodule

// [hw/dspi2c_if.sv]
// bus wires between display port and host controller
`timescale 1ns/10ps
interface dspi2c_if;
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	// open drain: line low when any enabled driver drives low
	logic scl;
	logic sda;
	assign scl = !(scl_oe && !scl_o);
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
	modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
	modport host (input scl, input sda, output scl_o, output scl_oe, output sda_h_o, output sda_h_oe);
endinterface

// [hw/dspi2c_pkg.sv]
// shared constants for the display two-wire register port
package dspi2c_pkg;
	// ---------------------------------------------------------------
	// addressing
	// ---------------------------------------------------------------
	localparam logic [5:0] ADDR_UPPER   = 6'h1D;          // 011101x
	localparam int         REG_COUNT    = 32;
	localparam logic [7:0] REG_MODE     = 8'h01;          // input mode register index
	localparam int         WPROT_BIT    = 4;              // register write protect bit
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam logic [7:0] REG_ID_VALUE = 8'h00;          // register 0 read-only, value arbitrary
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int SYS_CLK_HZ    = 20_000_000;
	localparam int BUS_MAX_HZ    = 400_000;
	// half period rounded up so the bus clock never exceeds the limit
	localparam int HALF_CYCLES   = (SYS_CLK_HZ + 2 * BUS_MAX_HZ - 1) / (2 * BUS_MAX_HZ);
	localparam int QTR_CYCLES    = (HALF_CYCLES + 1) / 2;
	localparam logic [7:0] HALF_COUNT = 8'(HALF_CYCLES);
	localparam logic [7:0] QTR_COUNT  = 8'(QTR_CYCLES);
	typedef enum logic [3:0] {
		DS_IDLE = 4'h0, DS_ADDR = 4'h1, DS_AACK = 4'h3, DS_RADDR = 4'h2,
		DS_WDATA = 4'h6, DS_WACK = 4'h7, DS_RDATA = 4'h5, DS_RACK = 4'h4
	} dspi2c_dstate_t;
	typedef enum logic [3:0] {
		HS_IDLE = 4'h0, HS_START = 4'h1, HS_BIT = 4'h3, HS_ACK = 4'h2,
		HS_STOP = 4'h6, HS_DONE = 4'h7
	} dspi2c_hstate_t;
endpackage

// [tb/dspi2c_props.sv]
// assertion checker for the two-wire link between host and display port
`timescale 1ns/10ps
module dspi2c_props (
	// system
	input wire logic SYS_CLK,
	input wire logic ARST_N,
	// host drivers
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_h_o,
	input wire logic sda_h_oe,
	// device drivers
	input wire logic sda_d_o,
	input wire logic sda_d_oe,
	// resolved wires
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// ---------------------------------------------------------------
	// bus clock period counter
	// ---------------------------------------------------------------
	logic [7:0] per_cnt;
	logic [7:0] next_per_cnt;
	logic       scl_q;
	logic       next_scl_q;
	// saturates so a long idle gap never wraps into a short count
	always_comb begin
		next_scl_q   = scl;
		next_per_cnt = (per_cnt == 8'hFF) ? per_cnt : per_cnt + 8'h01;
		if (scl && !scl_q) begin
			next_per_cnt = 8'h01;
		end
	end
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			per_cnt <= 8'hFF;
			scl_q   <= 1'h1;
		end else begin
			per_cnt <= next_per_cnt;
			scl_q   <= next_scl_q;
		end
	end
	// ---------------------------------------------------------------
	// wire events
	// ---------------------------------------------------------------
	sequence dev_pull_s;
		$rose(sda_d_oe) ##0 !scl;
	endsequence
	sequence start_s;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_s;
		scl && $past(scl) && $rose(sda);
	endsequence
	AST_SCL_PERIOD: assert property ($rose(scl) |-> per_cnt >= 8'h32)
		else $error("bus clock period below limit");
	AST_DEV_STABLE_HIGH: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
		else $error("device changed data while clock high");
	AST_DEV_PULL_LOW: assert property ($rose(sda_d_oe) |-> !scl)
		else $error("device pulled data while clock high");
	AST_DEV_FREE_LOW: assert property ($fell(sda_d_oe) |-> !scl)
		else $error("device released data while clock high");
	AST_START_BY_HOST: assert property (start_s |-> sda_h_oe)
		else $error("start not made by host");
	AST_STOP_BY_HOST: assert property (stop_s |-> $past(sda_h_oe) && !$past(sda_d_oe))
		else $error("stop not made by host");
	AST_DEV_SETUP: assert property (dev_pull_s |-> ##[1:30] (scl && sda_d_oe))
		else $error("device pull not held into clock high");
	AST_DEV_BOUNDED: assert property ($rose(sda_d_oe) |-> ##[1:520] !sda_d_oe)
		else $error("device held data line too long");
endmodule

// [tb/tb_display_i2c_register_slave.sv]
// self-checking bench: host master against display register port
`timescale 1ns/10ps
module tb_display_i2c_register_slave;
	typedef struct packed {
		logic       rd;
		logic       sel;
		logic       pin;
		logic [7:0] index;
		logic [7:0] wdata;
		logic       err;
		logic [7:0] rdata;
	} dspi2c_row_t;
	logic        sys_clk;
	logic        arst_n;
	logic        addr_pin;
	logic        ext_rst_pin;
	logic        busy;
	logic [7:0]  mode_reg;
	logic        req;
	logic        rd;
	logic        sel;
	logic [7:0]  index;
	logic [7:0]  wdata;
	logic        done;
	logic        err;
	logic [7:0]  rdata;
	logic [8:0]  mon_shift;
	logic [3:0]  mon_bits;
	logic [8:0]  mon_addr;
	int          bad_count;
	int          total_checks;
	dspi2c_row_t rows [8];
	// ---------------------------------------------------------------
	// both ends across one link
	// ---------------------------------------------------------------
	dspi2c_if dspi2c_if_inst ();
	dspi2c_device dspi2c_device_inst (.SYS_CLK(sys_clk), .ARST_N(arst_n), .BUS(dspi2c_if_inst.device),
		.ADDRESS_SELECT_PIN(addr_pin), .EXTERNAL_RESET_PIN(ext_rst_pin), .BUSY(busy), .MODE_REG(mode_reg));
	dspi2c_host dspi2c_host_inst (.SYS_CLK(sys_clk), .ARST_N(arst_n), .BUS(dspi2c_if_inst.host), .REQ(req),
		.RD(rd), .SEL(sel), .INDEX(index), .WDATA(wdata), .DONE(done), .ERR(err), .RDATA(rdata));
	dspi2c_props dspi2c_props_inst (.SYS_CLK(sys_clk), .ARST_N(arst_n), .scl_o(dspi2c_if_inst.scl_o),
		.scl_oe(dspi2c_if_inst.scl_oe), .sda_h_o(dspi2c_if_inst.sda_h_o), .sda_h_oe(dspi2c_if_inst.sda_h_oe),
		.sda_d_o(dspi2c_if_inst.sda_d_o), .sda_d_oe(dspi2c_if_inst.sda_d_oe), .scl(dspi2c_if_inst.scl),
		.sda(dspi2c_if_inst.sda));
	// wire monitor: first byte plus ack bit after every start
	always @(negedge dspi2c_if_inst.sda) begin
		if (dspi2c_if_inst.scl === 1'h1) begin
			mon_bits = 4'h0;
		end
	end
	always @(posedge dspi2c_if_inst.scl) begin
		if (mon_bits < 4'h9) begin
			mon_shift = {mon_shift[7:0], dspi2c_if_inst.sda};
			mon_bits  = mon_bits + 4'h1;
			mon_addr  = (mon_bits == 4'h9) ? mon_shift : mon_addr;
		end
	end
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one host transfer; a hung link ends the run
	task automatic do_op(input logic r, input logic s, input logic [7:0] i, input logic [7:0] w);
		int n;
		@(posedge sys_clk);
		req   <= 1'h1;
		rd    <= r;
		sel   <= s;
		index <= i;
		wdata <= w;
		@(posedge sys_clk);
		req <= 1'h0;
		for (n = 0; n < 5000 && done !== 1'h1; n++) @(negedge sys_clk);
		if (n == 5000) begin
			bad_count++;
			finish_test();
		end
	endtask
	task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
		do_op(1'h1, 1'h0, i, 8'h00);
		check("rdata", {1'h0, rdata}, {1'h0, e});
	endtask
	// ---------------------------------------------------------------
	// stimulus
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		{arst_n, addr_pin, req, rd, sel, index, wdata} = 21'h000000;
		ext_rst_pin  = 1'h1;
		{mon_bits, mon_shift, mon_addr} = {4'h9, 18'h00000};
		bad_count    = 0;
		total_checks = 0;
		// rd sel pin index wdata err rdata; reads of 02 and 1F prove decode
		rows[0] = '{1'h0, 1'h0, 1'h0, 8'h02, 8'hA5, 1'h0, 8'h00};
		rows[1] = '{1'h0, 1'h1, 1'h1, 8'h1F, 8'h3C, 1'h0, 8'h00};
		rows[2] = '{1'h1, 1'h0, 1'h0, 8'h02, 8'h00, 1'h0, 8'hA5};
		rows[3] = '{1'h1, 1'h1, 1'h1, 8'h1F, 8'h00, 1'h0, 8'h3C};
		rows[4] = '{1'h0, 1'h0, 1'h0, 8'h00, 8'hFF, 1'h0, 8'h00};
		rows[5] = '{1'h1, 1'h0, 1'h0, 8'h00, 8'h00, 1'h0, dspi2c_pkg::REG_ID_VALUE};
		rows[6] = '{1'h0, 1'h1, 1'h0, 8'h05, 8'h11, 1'h1, 8'h00};
		rows[7] = '{1'h1, 1'h0, 1'h1, 8'h05, 8'h00, 1'h1, 8'h00};
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'h1;
		for (int k = 0; k < 8; k++) begin
			@(posedge sys_clk);
			addr_pin <= rows[k].pin;
			do_op(rows[k].rd, rows[k].sel, rows[k].index, rows[k].wdata);
			check("err", {8'h00, err}, {8'h00, rows[k].err});
			check("addr", mon_addr, {dspi2c_pkg::ADDR_UPPER, rows[k].sel, rows[k].rd & ~rows[k].err, rows[k].err});
			if (rows[k].rd && !rows[k].err) check("rdata", {1'h0, rdata}, {1'h0, rows[k].rdata});
			$display("row %0d finished", k);
		end
		// write protect locks everything but the mode register
		@(posedge sys_clk);
		addr_pin <= 1'h0;
		do_op(1'h0, 1'h0, dspi2c_pkg::REG_MODE, 8'h10);
		check("mode", {1'h0, mode_reg}, 9'h010);
		do_op(1'h0, 1'h0, 8'h03, 8'h77);
		rd_chk(8'h03, 8'h00);
		do_op(1'h0, 1'h0, dspi2c_pkg::REG_MODE, 8'h00);
		check("mode", {1'h0, mode_reg}, 9'h000);
		do_op(1'h0, 1'h0, 8'h03, 8'h77);
		rd_chk(8'h03, 8'h77);
		$display("protect test finished");
		// external reset pin low refuses writes
		@(posedge sys_clk);
		ext_rst_pin <= 1'h0;
		do_op(1'h0, 1'h0, 8'h04, 8'h55);
		@(posedge sys_clk);
		ext_rst_pin <= 1'h1;
		rd_chk(8'h04, 8'h00);
		$display("pin test finished");
		// reset in mid-transfer: all released, registers back to reset value
		do_op(1'h0, 1'h0, dspi2c_pkg::REG_MODE, 8'h0F);
		@(posedge sys_clk);
		req <= 1'h1;
		@(posedge sys_clk);
		req <= 1'h0;
		repeat (300) @(negedge sys_clk);
		check("busy", {8'h00, busy}, 9'h001);
		@(posedge sys_clk);
		arst_n <= 1'h0;
		repeat (2) @(posedge sys_clk);
		arst_n <= 1'h1;
		@(negedge sys_clk);
		check("busy mode", {busy, mode_reg}, 9'h000);
		check("lines", {7'h00, dspi2c_if_inst.scl, dspi2c_if_inst.sda}, 9'h003);
		rd_chk(8'h03, dspi2c_pkg::REG_RESET);
		$display("reset test finished");
		finish_test();
	end
endmodule
